// ---- crx_rx_status.sv ----
// Receive status flags, bus state fields and receive interrupt enables
`timescale 1ns/100ps
`default_nettype none

module crx_rx_status #(
    parameter int CNT_W = crx_pkg::CNT_W
) (
    input  wire logic                      sys_clk,
    input  wire logic                      rst_n,
    input  wire logic [crx_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]                reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [7:0]                reg_rdata,
    input  wire logic                      init_request,
    input  wire logic                      init_acknowledge,
    input  wire logic [CNT_W-1:0]          rx_err_count,
    input  wire logic [CNT_W-1:0]          tx_err_count,
    input  wire logic                      wakeup_event,
    input  wire logic                      overrun_event,
    input  wire logic                      rx_fifo_pending,
    output logic                           rx_fifo_shift,
    output logic                           rx_buffer_release,
    output logic                           wakeup_irq,
    output logic                           error_irq,
    output logic                           rx_irq
);

    if (CNT_W < 9) begin : g_bad_width
        $error("crx_rx_status: counter must hold values above 255");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    logic init_mode;
    logic init_clear;
    logic wr_flags;
    logic wr_enable;

    assign init_mode  = init_request & init_acknowledge;
    assign init_clear = ~init_request & ~init_acknowledge;
    // Writes only once init fully exited, not during the handshake
    assign wr_flags   = reg_wr & init_clear & (reg_addr == crx_pkg::IDX_FLAGS);
    assign wr_enable  = reg_wr & init_clear & (reg_addr == crx_pkg::IDX_ENABLE);

    ////////////////////////////////////////////////////////////////////////////
    // Bus state from error counters

    logic                    tx_bus_off;
    crx_pkg::crx_bus_state_t rx_actual;
    crx_pkg::crx_bus_state_t tx_actual;

    assign tx_bus_off = tx_err_count > CNT_W'(crx_pkg::BUSOFF_LIMIT);

    // Receiver reports bus-off too, and falls back to the state of its own counter when it ends
    crx_state_class #(.CNT_W(CNT_W)) u_rx_class (
        .err_count (rx_err_count),
        .bus_off   (tx_bus_off),
        .state     (rx_actual)
    );

    crx_state_class #(.CNT_W(CNT_W)) u_tx_class (
        .err_count (tx_err_count),
        .bus_off   (tx_bus_off),
        .state     (tx_actual)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Change detection against last actual state

    crx_pkg::crx_bus_state_t rx_prev_r;
    crx_pkg::crx_bus_state_t tx_prev_r;

    function automatic logic sens_hit(
        input crx_pkg::crx_sens_t      sens,
        input crx_pkg::crx_bus_state_t old_st,
        input crx_pkg::crx_bus_state_t new_st
    );
        logic hit;
        hit = 1'b0;
        if (old_st != new_st) begin
            unique case (sens)
                crx_pkg::SENS_NONE: begin
                    hit = 1'b0;
                end
                crx_pkg::SENS_BUSOFF: begin
                    hit = (old_st == crx_pkg::ST_BUSOFF) | (new_st == crx_pkg::ST_BUSOFF);
                end
                crx_pkg::SENS_PASSIVE: begin
                    hit = old_st[1] | new_st[1];
                end
                crx_pkg::SENS_ALL: begin
                    hit = 1'b1;
                end
            endcase
        end
        return hit;
    endfunction

    // Previous state is not reset by init, so no false change on exit
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_prev_r <= crx_pkg::ST_OK;
            tx_prev_r <= crx_pkg::ST_OK;
        end else begin
            rx_prev_r <= rx_actual;
            tx_prev_r <= tx_actual;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sensitivity and enable register

    crx_pkg::crx_sens_t rx_sens_r;
    crx_pkg::crx_sens_t tx_sens_r;
    logic               wakeup_irq_enable_r;
    logic               status_change_irq_enable_r;
    logic               overrun_irq_enable_r;
    logic               rx_full_irq_enable_r;

    // Sensitivities are outside the init-mode hold
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_sens_r <= crx_pkg::SENS_NONE;
            tx_sens_r <= crx_pkg::SENS_NONE;
        end else if (wr_enable) begin
            rx_sens_r <= crx_pkg::crx_sens_t'(
                reg_wdata[crx_pkg::RX_FIELD_HI:crx_pkg::RX_FIELD_LO]);
            tx_sens_r <= crx_pkg::crx_sens_t'(
                reg_wdata[crx_pkg::TX_FIELD_HI:crx_pkg::TX_FIELD_LO]);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wakeup_irq_enable_r        <= 1'b0;
            status_change_irq_enable_r <= 1'b0;
            overrun_irq_enable_r       <= 1'b0;
            rx_full_irq_enable_r       <= 1'b0;
        end else if (init_mode) begin
            wakeup_irq_enable_r        <= 1'b0;
            status_change_irq_enable_r <= 1'b0;
            overrun_irq_enable_r       <= 1'b0;
            rx_full_irq_enable_r       <= 1'b0;
        end else if (wr_enable) begin
            wakeup_irq_enable_r        <= reg_wdata[crx_pkg::BIT_WAKEUP];
            status_change_irq_enable_r <= reg_wdata[crx_pkg::BIT_STATUS_CHG];
            overrun_irq_enable_r       <= reg_wdata[crx_pkg::BIT_OVERRUN];
            rx_full_irq_enable_r       <= reg_wdata[crx_pkg::BIT_RX_FULL];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flags: event set wins over software clear

    logic wakeup_flag_r;
    logic status_change_flag_r;
    logic overrun_flag_r;
    logic rx_full_flag_r;
    logic status_change_set;
    logic rx_full_set;

    assign status_change_set = ~init_mode &
                               (sens_hit(rx_sens_r, rx_prev_r, rx_actual) |
                                sens_hit(tx_sens_r, tx_prev_r, tx_actual));

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wakeup_flag_r <= 1'b0;
        end else if (init_mode) begin
            wakeup_flag_r <= 1'b0;
        end else if (wakeup_event) begin
            wakeup_flag_r <= 1'b1;
        end else if (wr_flags && reg_wdata[crx_pkg::BIT_WAKEUP]) begin
            wakeup_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_change_flag_r <= 1'b0;
        end else if (init_mode) begin
            status_change_flag_r <= 1'b0;
        end else if (status_change_set) begin
            status_change_flag_r <= 1'b1;
        end else if (wr_flags && reg_wdata[crx_pkg::BIT_STATUS_CHG]) begin
            status_change_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            overrun_flag_r <= 1'b0;
        end else if (init_mode) begin
            overrun_flag_r <= 1'b0;
        end else if (overrun_event) begin
            overrun_flag_r <= 1'b1;
        end else if (wr_flags && reg_wdata[crx_pkg::BIT_OVERRUN]) begin
            overrun_flag_r <= 1'b0;
        end
    end

    // Shift only when foreground is free; one-cycle gap lets pending settle
    assign rx_full_set = ~init_mode & ~rx_full_flag_r & ~rx_fifo_shift
                         & rx_fifo_pending;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_full_flag_r <= 1'b0;
        end else if (init_mode) begin
            rx_full_flag_r <= 1'b0;
        end else if (rx_full_set) begin
            rx_full_flag_r <= 1'b1;
        end else if (wr_flags && reg_wdata[crx_pkg::BIT_RX_FULL]) begin
            rx_full_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_fifo_shift     <= 1'b0;
            rx_buffer_release <= 1'b0;
        end else begin
            rx_fifo_shift     <= rx_full_set;
            rx_buffer_release <= wr_flags & reg_wdata[crx_pkg::BIT_RX_FULL]
                                 & rx_full_flag_r & ~init_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reported bus-state fields

    crx_pkg::crx_bus_state_t rx_field_r;
    crx_pkg::crx_bus_state_t tx_field_r;

    // Frozen while a change is pending so software sees the cause
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_field_r <= crx_pkg::ST_OK;
            tx_field_r <= crx_pkg::ST_OK;
        end else if (!status_change_flag_r) begin
            rx_field_r <= rx_actual;
            tx_field_r <= tx_actual;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt requests

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wakeup_irq <= 1'b0;
            error_irq  <= 1'b0;
            rx_irq     <= 1'b0;
        end else begin
            wakeup_irq <= wakeup_flag_r & wakeup_irq_enable_r;
            error_irq  <= (status_change_flag_r & status_change_irq_enable_r)
                          | (overrun_flag_r & overrun_irq_enable_r);
            rx_irq     <= rx_full_flag_r & rx_full_irq_enable_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port

    logic [7:0] flags_view;
    logic [7:0] enable_view;

    assign flags_view  = {wakeup_flag_r, status_change_flag_r, rx_field_r, tx_field_r,
                          overrun_flag_r, rx_full_flag_r};
    assign enable_view = {wakeup_irq_enable_r, status_change_irq_enable_r, rx_sens_r,
                          tx_sens_r, overrun_irq_enable_r, rx_full_irq_enable_r};

    // Reads allowed at any time; unmapped reads return zero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= crx_pkg::DATA_ZERO;
        end else if (reg_rd && reg_addr == crx_pkg::IDX_FLAGS) begin
            reg_rdata <= flags_view;
        end else if (reg_rd && reg_addr == crx_pkg::IDX_ENABLE) begin
            reg_rdata <= enable_view;
        end else begin
            reg_rdata <= crx_pkg::DATA_ZERO;
        end
    end

endmodule // crx_rx_status

`default_nettype wire

// ---- crx_pkg.sv ----
// Shared constants for the receive status flag and interrupt enable block
package crx_pkg;

    // Register index on the plain register port
    localparam int          ADDR_W          = 2;
    localparam logic [1:0]  IDX_FLAGS       = 2'h0;
    localparam logic [1:0]  IDX_ENABLE      = 2'h1;

    // Field positions, shared by flags and enables
    localparam int          BIT_WAKEUP      = 7;
    localparam int          BIT_STATUS_CHG  = 6;
    localparam int          RX_FIELD_HI     = 5;
    localparam int          RX_FIELD_LO     = 4;
    localparam int          TX_FIELD_HI     = 3;
    localparam int          TX_FIELD_LO     = 2;
    localparam int          BIT_OVERRUN     = 1;
    localparam int          BIT_RX_FULL     = 0;

    // Reset values
    localparam logic [7:0]  DATA_ZERO       = 8'h00;
    localparam logic [1:0]  FIELD_ZERO      = 2'h0;

    // Error counter width and thresholds
    localparam int          CNT_W           = 9;
    localparam logic [8:0]  WARN_LIMIT      = 9'h060;
    localparam logic [8:0]  PASSIVE_LIMIT   = 9'h07f;
    localparam logic [8:0]  BUSOFF_LIMIT    = 9'h0ff;

    // Bus state encoding, same for receiver and transmitter
    typedef enum logic [1:0] {
        ST_OK      = 2'b00,
        ST_WARN    = 2'b01,
        ST_PASSIVE = 2'b10,
        ST_BUSOFF  = 2'b11
    } crx_bus_state_t;

    // Change sensitivity encoding
    typedef enum logic [1:0] {
        SENS_NONE    = 2'b00,
        SENS_BUSOFF  = 2'b01,
        SENS_PASSIVE = 2'b10,
        SENS_ALL     = 2'b11
    } crx_sens_t;

endpackage

// ---- crx_state_class.sv ----
// Error counter to bus state classifier
`timescale 1ns/100ps
`default_nettype none

module crx_state_class #(
    parameter int CNT_W = crx_pkg::CNT_W
) (
    input  wire logic [CNT_W-1:0]      err_count,
    input  wire logic                  bus_off,
    output var  crx_pkg::crx_bus_state_t state
);

    if (CNT_W < 9) begin : g_bad_width
        $error("crx_state_class: counter must hold values above 255");
    end

    always_comb begin
        if (bus_off) begin
            state = crx_pkg::ST_BUSOFF;
        end else if (err_count > CNT_W'(crx_pkg::PASSIVE_LIMIT)) begin
            state = crx_pkg::ST_PASSIVE;
        end else if (err_count > CNT_W'(crx_pkg::WARN_LIMIT)) begin
            state = crx_pkg::ST_WARN;
        end else begin
            state = crx_pkg::ST_OK;
        end
    end

endmodule // crx_state_class

`default_nettype wire

// ---- crx_rx_status_sva.sv ----
// Port checker for the receive status block
`timescale 1ns/100ps
`default_nettype none

module crx_rx_status_chk (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       init_request,
    input wire logic       init_acknowledge,
    input wire logic       wakeup_event,
    input wire logic       overrun_event,
    input wire logic       rx_fifo_shift,
    input wire logic       rx_buffer_release,
    input wire logic       wakeup_irq,
    input wire logic       error_irq,
    input wire logic       rx_irq
);
    logic       init_m;
    logic       wr_ok;
    logic       clr_full;
    logic [7:0] en_r;
    logic       full_r;
    assign init_m = init_request & init_acknowledge;
    assign wr_ok = reg_wr & ~init_request & ~init_acknowledge;
    assign clr_full = wr_ok && reg_addr == crx_pkg::IDX_FLAGS && reg_wdata[0];
    // Shadow enables: sensitivities survive init mode
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) en_r <= 8'h00;
        else if (init_m) en_r <= en_r & 8'h3c;
        else if (wr_ok && reg_addr == crx_pkg::IDX_ENABLE) en_r <= reg_wdata;
    end
    // Lags the real flag by a cycle; a clear in the shift cycle beats the late set
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) full_r <= 1'b0;
        else if (init_m || clr_full) full_r <= 1'b0;
        else if (rx_fifo_shift) full_r <= 1'b1;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence ovr_seen;
        overrun_event && !init_m && en_r[1];
    endsequence
    sequence wake_seen;
        wakeup_event && !init_m && en_r[7];
    endsequence
    shift_gap_a: assert property (rx_fifo_shift |=> !rx_fifo_shift)
        else $error("shift longer than one cycle");
    shift_full_a: assert property (rx_fifo_shift |-> !full_r)
        else $error("shift while buffer full");
    rx_irq_a: assert property (rx_fifo_shift && en_r[0] && !init_m |=> rx_irq)
        else $error("receive request missing");
    rx_mask_a: assert property (!en_r[0] |=> !rx_irq)
        else $error("receive request while masked");
    ovr_irq_a: assert property (ovr_seen |-> ##2 error_irq)
        else $error("overrun request missing");
    err_mask_a: assert property (!en_r[1] && !en_r[6] |=> !error_irq)
        else $error("error request while masked");
    wake_irq_a: assert property (wake_seen |-> ##2 wakeup_irq)
        else $error("wake-up request missing");
    wake_mask_a: assert property (!en_r[7] |=> !wakeup_irq)
        else $error("wake-up request while masked");
    release_a: assert property (clr_full && full_r |=> rx_buffer_release)
        else $error("buffer release missing");
    en_read_a: assert property (reg_rd && reg_addr == crx_pkg::IDX_ENABLE
        |=> reg_rdata == $past(en_r))
        else $error("enable readback wrong");
    init_clr_a: assert property (init_m |-> ##2 !rx_irq && !error_irq && !wakeup_irq)
        else $error("request survives init mode");
endmodule // crx_rx_status_chk

bind crx_rx_status crx_rx_status_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .init_request(init_request), .init_acknowledge(init_acknowledge),
    .wakeup_event(wakeup_event), .overrun_event(overrun_event), .rx_fifo_shift(rx_fifo_shift),
    .rx_buffer_release(rx_buffer_release), .wakeup_irq(wakeup_irq), .error_irq(error_irq),
    .rx_irq(rx_irq));
`default_nettype wire

// ---- crx_can_engine.sv ----
// Behavioural receive FIFO of the protocol engine
`timescale 1ns/100ps
`default_nettype none

module crx_can_engine (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       push_msg,
    input  wire logic       rx_fifo_shift,
    output logic            rx_fifo_pending,
    output logic [7:0]      shift_count
);
    logic [3:0] held_r;
    // Each cycle with push_msg high queues one message; pending drops one edge after the last shift
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            held_r <= 4'h0;
            shift_count <= 8'h00;
        end else begin
            held_r <= held_r + {3'h0, push_msg} - {3'h0, rx_fifo_shift};
            if (rx_fifo_shift) shift_count <= shift_count + 8'h01;
        end
    end
    assign rx_fifo_pending = (held_r != 4'h0);
endmodule // crx_can_engine
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the receive status block
`timescale 1ns/100ps
`default_nettype none

module testbench;
    localparam logic [1:0] FL = crx_pkg::IDX_FLAGS;
    localparam logic [1:0] EN = crx_pkg::IDX_ENABLE;
    logic       sys_clk, rst_n, reg_wr, reg_rd, init_request, init_acknowledge;
    logic       wakeup_event, overrun_event, push_msg, rd_seen, hit;
    logic       rx_fifo_pending, rx_fifo_shift, rx_buffer_release, wakeup_irq, error_irq, rx_irq;
    logic [1:0] reg_addr, s;
    logic [7:0] reg_wdata, reg_rdata, shift_count, bitv, rel_count;
    logic [8:0] rx_err_count, tx_err_count;
    logic [31:0] rng;
    logic [7:0] exp_q[$];
    int         err_count, checks;
    crx_rx_status #(.CNT_W(crx_pkg::CNT_W)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .init_request(init_request), .init_acknowledge(init_acknowledge),
        .rx_err_count(rx_err_count), .tx_err_count(tx_err_count), .wakeup_event(wakeup_event),
        .overrun_event(overrun_event), .rx_fifo_pending(rx_fifo_pending),
        .rx_fifo_shift(rx_fifo_shift), .rx_buffer_release(rx_buffer_release),
        .wakeup_irq(wakeup_irq), .error_irq(error_irq), .rx_irq(rx_irq));
    crx_can_engine peer (.sys_clk(sys_clk), .rst_n(rst_n), .push_msg(push_msg),
        .rx_fifo_shift(rx_fifo_shift), .rx_fifo_pending(rx_fifo_pending),
        .shift_count(shift_count));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // A gap cycle after each strobe keeps one assignment per time step
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        tick(1);
        reg_wr <= 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        tick(1);
        reg_rd <= 1'b0;
        tick(1);
    endtask
    task automatic irq_chk(input logic [2:0] e);
        @(negedge sys_clk);
        chk("irqs", {5'h00, e}, {5'h00, wakeup_irq, error_irq, rx_irq});
        tick(1);
    endtask
    task automatic stop_test();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge sys_clk) rd_seen <= reg_rd;
    always @(negedge sys_clk) begin
        if (rd_seen === 1'b1) chk("reg_rdata", exp_q.pop_front(), reg_rdata);
    end
    // Counts buffer release pulses seen on the port
    always @(posedge sys_clk) begin
        if (rst_n !== 1'b1) rel_count <= 8'h00;
        else if (rx_buffer_release === 1'b1) rel_count <= rel_count + 8'h01;
    end
    initial begin
        #100000;
        err_count++;
        stop_test();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, reg_wr, reg_rd, init_request, init_acknowledge} = 5'h00;
        {wakeup_event, overrun_event, push_msg, reg_addr, reg_wdata} = 13'h0000;
        rx_err_count = 9'h000;
        tx_err_count = 9'h000;
        rng = 32'h33;
        tick(10);
        rst_n <= 1'b1;
        tick(2);
        rd(FL, 8'h00);
        rd(EN, 8'h00);
        wr(2'h2, 8'hff);
        rd(2'h2, 8'h00);
        wr(FL, 8'hff);
        rd(FL, 8'h00);
        for (int k = 0; k < 4; k++) begin
            wr(EN, (k < 2) ? 8'h83 : 8'h00);
            if (k[0]) wakeup_event <= 1'b1;
            else overrun_event <= 1'b1;
            tick(1);
            overrun_event <= 1'b0;
            wakeup_event <= 1'b0;
            tick(2);
            bitv = k[0] ? 8'h80 : 8'h02;
            irq_chk((k >= 2) ? 3'b000 : (k[0] ? 3'b100 : 3'b010));
            wr(FL, 8'h00);
            rd(FL, bitv);
            wr(FL, bitv);
            rd(FL, 8'h00);
        end
        for (int j = 0; j < 8; j++) begin
            rng = xs(rng);
            s = 2'(j);
            hit = (j < 4) ? s[1] : (s == 2'h3);
            wr(EN, {2'b01, (j < 4) ? {2'b00, s} : {s, 2'b00}, 2'b00});
            if (j < 4) tx_err_count <= 9'h080 + {2'h0, rng[6:0]};
            else rx_err_count <= 9'h061 + {5'h00, rng[3:0]};
            tick(4);
            rd(FL, {1'b0, hit, (j < 4) ? 4'b0010 : 4'b0100, 2'b00});
            irq_chk({1'b0, hit, 1'b0});
            tx_err_count <= 9'h000;
            rx_err_count <= 9'h000;
            tick(4);
            wr(FL, 8'h40);
            rd(FL, 8'h00);
        end
        wr(EN, 8'h44);
        tx_err_count <= 9'h100;
        tick(4);
        wr(FL, 8'h3c);
        rd(FL, 8'h7c);
        tx_err_count <= 9'h000;
        tick(4);
        rd(FL, 8'h7c);
        wr(FL, 8'h40);
        rd(FL, 8'h00);
        wr(EN, 8'h01);
        push_msg <= 1'b1;
        tick(2);
        push_msg <= 1'b0;
        tick(4);
        irq_chk(3'b001);
        rd(FL, 8'h01);
        chk("shift_count", 8'h01, shift_count);
        wr(FL, 8'h01);
        tick(3);
        chk("shift_count", 8'h02, shift_count);
        wr(FL, 8'h01);
        rd(FL, 8'h00);
        wr(EN, 8'hff);
        tx_err_count <= 9'h090;
        overrun_event <= 1'b1;
        tick(1);
        overrun_event <= 1'b0;
        init_request <= 1'b1;
        tick(1);
        init_acknowledge <= 1'b1;
        tick(2);
        wr(EN, 8'h00);
        rd(EN, 8'h3c);
        rd(FL, 8'h08);
        init_request <= 1'b0;
        init_acknowledge <= 1'b0;
        tick(2);
        wr(EN, 8'h02);
        rd(EN, 8'h02);
        tick(2);
        chk("release_count", 8'h02, rel_count);
        stop_test();
    end
endmodule // testbench
`default_nettype wire
